/* File: dps_hist.sv */
/*
 * Tuning-word history: running average of the last eight locked words.
 * Assumes samples arrive only while the loop is locked.
 */
module dps_hist
    import dps_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst_n,
    dps_hist_if.hist    h
);
    // ************************************************************
    // Ring and running sum
    // ************************************************************
    logic [NUM_W-1:0]         mem [HIST_N];
    logic [HIST_AW-1:0]       wp_reg,  wp_next;
    logic [NUM_W+HIST_AW-1:0] sum_reg, sum_next;
    logic                     full_reg, full_next;
    logic [NUM_W-1:0]         avg_reg, avg_next;

    always_comb begin
        wp_next   = wp_reg;
        sum_next  = sum_reg;
        full_next = full_reg;
        if (h.sample) begin
            // Until full the oldest slot holds nothing to subtract
            sum_next = sum_reg + {{HIST_AW{1'b0}}, h.word}
                     - (full_reg ? {{HIST_AW{1'b0}}, mem[wp_reg]}
                                 : '0);
            wp_next  = wp_reg + 3'h1;
            if (wp_reg == 3'h7) begin
                full_next = 1'b1;
            end
        end
        avg_next = sum_next[NUM_W+HIST_AW-1:HIST_AW];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wp_reg   <= '0;
            sum_reg  <= '0;
            full_reg <= 1'b0;
            avg_reg  <= '0;
        end else begin
            wp_reg   <= wp_next;
            sum_reg  <= sum_next;
            full_reg <= full_next;
            avg_reg  <= avg_next;
            if (h.sample) begin
                mem[wp_reg] <= h.word;
            end
        end
    end

    assign h.avg   = avg_reg;
    assign h.valid = full_reg;
endmodule : dps_hist

/* File: dps_hist_if.sv */
/*
 * Carrier between the loop and its tuning-word history.
 * Assumes both ends run on mclk.
 */
interface dps_hist_if;
    logic                       sample;
    logic [dps_pkg::NUM_W-1:0]  word;
    logic [dps_pkg::NUM_W-1:0]  avg;
    logic                       valid;
    modport loop (output sample, output word, input avg, input valid);
    modport hist (input sample, input word, output avg, output valid);
endinterface : dps_hist_if

/* File: dps_pkg.sv */
/*
 * Constants, reset defaults and types of the DPLL reference selector.
 * Assumes one 20 MHz clock and synchronous inputs.
 */
package dps_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NREF     = 2;
    localparam int NMON     = 5;   // Freq, missing, early, runt, 1PPS
    localparam int MON_W    = 8;
    localparam int NUM_W    = 40;  // Fractional divider resolution
    localparam int DEN24_W  = 24;
    localparam int ERR_W    = 16;
    localparam int SH_W     = 4;
    localparam int PRIO_W   = 2;
    localparam int HIST_AW  = 3;
    localparam int HIST_N   = 8;
    localparam int LK_W     = 5;
    // ************************************************************
    // Monitor field positions
    // ************************************************************
    localparam int MON_FREQ = 0;
    localparam int MON_MISS = 1;
    localparam int MON_EARLY = 2;
    localparam int MON_RUNT = 3;
    localparam int MON_PPS  = 4;
    // ************************************************************
    // Built-in read-only defaults
    // ************************************************************
    localparam logic [SH_W-1:0]  ROM_KP_SH = 4'h4;
    localparam logic [SH_W-1:0]  ROM_KI_SH = 4'h8;
    localparam logic [NUM_W-1:0] ROM_FREQUENCY_DEVIATION_STEP  = 40'h00_0000_0001;
    localparam logic [NUM_W-1:0] NUM_NOM   = 40'h80_0000_0000;
    localparam logic [NUM_W-1:0] DEN_FIXED = 40'hFF_FFFF_FFFF;
    localparam logic [ERR_W-1:0] LOCK_THR  = 16'h0004;
    localparam logic [LK_W-1:0]  LOCK_CNT  = 5'h10;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        DPS_FREE = 2'b00,
        DPS_ACQ  = 2'b01,
        DPS_LOCK = 2'b10,
        DPS_HOLD = 2'b11
    } dps_state_e;
    typedef logic [NREF-1:0][NMON-1:0][MON_W-1:0] dps_mon_t;
    typedef logic [NREF-1:0][NMON-1:0]            dps_men_t;
endpackage : dps_pkg

/* File: dps_ref_model.sv */
/*
 * Far-side model: reference input edges and feedback divider edges.
 * Assumes the bench clock and reset; all edges stand still when off.
 */
module dps_ref_model #(
    parameter int PER = 8,
    parameter int LAG = 1
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       run,
    output logic [1:0]      ref_edge,
    output logic            casc_edge,
    output logic            fb_edge
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Edge generator
    // ************************************************************
    logic [7:0] cnt_reg;
    // Feedback trails the references by a small fixed lag
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            cnt_reg   <= 8'h00;
            ref_edge  <= 2'h0;
            casc_edge <= 1'b0;
            fb_edge   <= 1'b0;
        end else begin
            cnt_reg   <= (cnt_reg == 8'(PER - 1)) ? 8'h00 : cnt_reg + 8'h01;
            ref_edge  <= {2{cnt_reg == 8'h00}};
            casc_edge <= (cnt_reg == 8'h00);
            fb_edge   <= (cnt_reg == 8'(LAG));
        end
    end
endmodule : dps_ref_model

/* File: dps_top.sv */
/*
 * DPLL control: reference selection, monitors, holdover, phase
 * detector, loop filter, offset stepping and denominator choice.
 * Assumes synchronous inputs and edge pulses one mclk wide.
 */
// Summary of operation
// - Auto select by priority, skipping failed inputs
// - Manual select by software or pin
// - Loss of reference: hitless switch or holdover
// - Any enabled monitor over threshold flags loss
// - Per-input threshold and enable for each monitor
// - Holdover word from averaged locked history
// - Source is reference inputs or cascade divider
// - Phase detector, loop filter, 40-bit divider
// - Offset step adds or subtracts deviation step
// - Offset stepping by software or pin
// - Fixed 40-bit or programmable 24-bit denominator
// - Analog reference: crystal or cascade output
// - Status on pins and sticky status bits
// - Settings load from built-in defaults at reset
// - Phase error filtered drives feedback numerator
// - First correction unfiltered, later ones filtered
// - Select 0 gives 24-bit, 1 gives 40-bit
module dps_top
    import dps_pkg::*;
(
    input  wire logic                                   mclk,
    input  wire logic                                   rst_n,
    input  wire logic [dps_pkg::NREF-1:0]               ref_edge,
    input  wire logic                                   casc_edge,
    input  wire logic                                   fb_edge,
    input  wire dps_pkg::dps_mon_t                      mon_level,
    input  wire dps_pkg::dps_mon_t                      mon_thr,
    input  wire dps_pkg::dps_men_t                      mon_en,
    input  wire logic [dps_pkg::NREF-1:0][dps_pkg::PRIO_W-1:0] prio,
    input  wire logic                                   man_sw,
    input  wire logic                                   man_pin,
    input  wire logic                                   man_sel_sw,
    input  wire logic                                   man_sel_pin,
    input  wire logic                                   src_casc,
    input  wire logic                                   apll_ref_cfg,
    input  wire logic                                   dco_en,
    input  wire logic                                   step_up_sw,
    input  wire logic                                   step_dn_sw,
    input  wire logic                                   step_up_pin,
    input  wire logic                                   step_dn_pin,
    input  wire logic                                   cfg_wr,
    input  wire logic [dps_pkg::SH_W-1:0]               cfg_kp_sh,
    input  wire logic [dps_pkg::SH_W-1:0]               cfg_ki_sh,
    input  wire logic [dps_pkg::NUM_W-1:0]              cfg_frequency_deviation_step,
    input  wire logic                                   denominator_select,
    input  wire logic [dps_pkg::DEN24_W-1:0]            den24_cfg,
    input  wire logic [dps_pkg::NREF-1:0]               lor_clr,
    output logic [dps_pkg::NUM_W-1:0]                   num_reg,
    output logic [dps_pkg::NUM_W-1:0]                   den_reg,
    output logic                                        sel_reg,
    output dps_pkg::dps_state_e                         state_reg,
    output logic [dps_pkg::NREF-1:0]                    lor_reg,
    output logic [dps_pkg::NREF-1:0]                    lor_sticky_reg,
    output logic                                        locked_reg,
    output logic                                        apll_ref_reg
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [NUM_W-1:0] sx(input logic [ERR_W-1:0] v);
        return {{(NUM_W-ERR_W){v[ERR_W-1]}}, v};
    endfunction : sx

    function automatic logic mon_fail(input int i, input dps_mon_t lv,
                                      input dps_mon_t th,
                                      input dps_men_t en);
        logic f;
        f = 1'b0;
        for (int m = 0; m < NMON; m++) begin
            f = f | (en[i][m] & (lv[i][m] > th[i][m]));
        end
        return f;
    endfunction : mon_fail

    dps_hist_if hif ();
    dps_hist u_hist (.mclk(mclk), .rst_n(rst_n), .h(hif));

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic [NREF-1:0]  lor_next, stk_next, qual;
    logic [SH_W-1:0]  kp_reg, kp_next, ki_reg, ki_next;
    logic [NUM_W-1:0] frequency_deviation_step_reg, frequency_deviation_step_next, dco_reg, dco_next;
    logic [NUM_W-1:0] integ_reg, integ_next, tw_reg, tw_next;
    logic [ERR_W-1:0] tdc_reg, tdc_next, err, mag;
    logic [LK_W-1:0]  lk_reg, lk_next;
    logic             first_reg, first_next, sel_next, man, man_sel;
    logic             best, any_q, edge_in, sel_lor, up, dn, ev;
    dps_state_e       state_next;
    logic [NUM_W-1:0] num_next, den_next, ki_term, kp_term;
    logic             locked_next;
    logic signed [NUM_W-1:0] serr;

    always_comb begin
        for (int i = 0; i < NREF; i++) begin
            lor_next[i] = mon_fail(i, mon_level, mon_thr, mon_en);
        end
        qual     = ~lor_reg;
        stk_next = (lor_sticky_reg & ~lor_clr) | lor_reg;
        any_q    = |qual;
        // Lower priority code wins; ties go to input 0
        best = qual[1] & (~qual[0] | (prio[1] < prio[0]));
        man     = man_sw | man_pin;
        man_sel = man_pin ? man_sel_pin : man_sel_sw;
        sel_lor = ~src_casc & lor_reg[sel_reg];
        edge_in = src_casc ? casc_edge : ref_edge[sel_reg];
        // Settings come from defaults, then software may rewrite them
        kp_next   = cfg_wr ? cfg_kp_sh : kp_reg;
        ki_next   = cfg_wr ? cfg_ki_sh : ki_reg;
        frequency_deviation_step_next = cfg_wr ? cfg_frequency_deviation_step  : frequency_deviation_step_reg;
        // Phase detector: cycles from reference edge to feedback edge
        tdc_next = edge_in ? '0 : tdc_reg + 16'h0001;
        err = tdc_reg;
        ev  = fb_edge & (state_reg == DPS_ACQ || state_reg == DPS_LOCK);
        mag = err[ERR_W-1] ? -err : err;
        lk_next = lk_reg;
        if (ev) begin
            lk_next = (mag > LOCK_THR) ? '0
                    : (lk_reg == LOCK_CNT) ? lk_reg : lk_reg + 5'h01;
        end
        integ_next = integ_reg;
        tw_next    = tw_reg;
        first_next = first_reg;
        // Shift alone in a signed context, or negative errors lose sign
        serr    = sx(err);
        ki_term = serr >>> ki_reg;
        kp_term = serr >>> kp_reg;
        if (ev && first_reg) begin
            integ_next = integ_reg + sx(err);
            tw_next    = NUM_NOM + integ_next;
            first_next = 1'b0;
        end else if (ev) begin
            integ_next = integ_reg + ki_term;
            tw_next    = NUM_NOM + integ_next + kp_term;
        end
        up = step_up_sw | step_up_pin;
        dn = step_dn_sw | step_dn_pin;
        dco_next = dco_reg;
        if (dco_en && up && !dn) begin
            dco_next = dco_reg + frequency_deviation_step_reg;
        end else if (dco_en && dn && !up) begin
            dco_next = dco_reg - frequency_deviation_step_reg;
        end
        sel_next   = sel_reg;
        state_next = state_reg;
        unique case (state_reg)
            DPS_FREE: begin
                if (any_q || src_casc) begin
                    sel_next   = man ? man_sel : best;
                    state_next = DPS_ACQ;
                    first_next = 1'b1;
                end
            end
            DPS_ACQ, DPS_LOCK: begin
                state_next = (lk_next == LOCK_CNT) ? DPS_LOCK : DPS_ACQ;
                if (man && man_sel != sel_reg && qual[man_sel]) begin
                    sel_next = man_sel;
                end else if (sel_lor) begin
                    if (!man && qual[~sel_reg]) begin
                        // Loop state kept, so the switch is hitless
                        sel_next = ~sel_reg;
                    end else begin
                        state_next = DPS_HOLD;
                        lk_next    = '0;
                        if (hif.valid) begin
                            tw_next = hif.avg;
                        end
                    end
                end else if (!man && !src_casc && best != sel_reg
                             && prio[best] < prio[sel_reg]) begin
                    sel_next = best;
                end
            end
            DPS_HOLD: begin
                if (any_q) begin
                    sel_next   = man ? man_sel : best;
                    state_next = DPS_ACQ;
                    first_next = 1'b1;
                    integ_next = tw_reg - NUM_NOM;
                end
            end
        endcase
        locked_next = (state_next == DPS_LOCK);
        num_next    = tw_next + dco_next;
        den_next    = denominator_select ? DEN_FIXED
                    : {{(NUM_W-DEN24_W){1'b0}}, den24_cfg};
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            kp_reg         <= ROM_KP_SH;
            ki_reg         <= ROM_KI_SH;
            frequency_deviation_step_reg       <= ROM_FREQUENCY_DEVIATION_STEP;
            dco_reg        <= '0;
            integ_reg      <= '0;
            tw_reg         <= NUM_NOM;
            tdc_reg        <= '0;
            lk_reg         <= '0;
            first_reg      <= 1'b1;
            sel_reg        <= 1'b0;
            state_reg      <= DPS_FREE;
            lor_reg        <= '0;
            lor_sticky_reg <= '0;
            locked_reg     <= 1'b0;
            num_reg        <= NUM_NOM;
            den_reg        <= DEN_FIXED;
            apll_ref_reg   <= 1'b0;
        end else begin
            kp_reg         <= kp_next;
            ki_reg         <= ki_next;
            frequency_deviation_step_reg       <= frequency_deviation_step_next;
            dco_reg        <= dco_next;
            integ_reg      <= integ_next;
            tw_reg         <= tw_next;
            tdc_reg        <= tdc_next;
            lk_reg         <= lk_next;
            first_reg      <= first_next;
            sel_reg        <= sel_next;
            state_reg      <= state_next;
            lor_reg        <= lor_next;
            lor_sticky_reg <= stk_next;
            locked_reg     <= locked_next;
            num_reg        <= num_next;
            den_reg        <= den_next;
            apll_ref_reg   <= apll_ref_cfg;
        end
    end

    // History only learns from locked words
    assign hif.sample = ev && state_reg == DPS_LOCK;
    assign hif.word   = tw_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_lor;
        mon_en[0][MON_RUNT] && mon_level[0][MON_RUNT] > mon_thr[0][MON_RUNT]
        |=> lor_reg[0];
    endproperty
    a_lor: assert property (p_lor) else $error("monitor fail not flagged");
    property p_stk;
        lor_reg[1] |=> lor_sticky_reg[1];
    endproperty
    a_stk: assert property (p_stk) else $error("sticky bit lost");
    property p_hold;
        state_reg == DPS_LOCK && !src_casc && lor_reg == 2'b11
        |=> state_reg == DPS_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("holdover not entered");
    property p_sw;
        state_reg == DPS_LOCK && !man && !src_casc && lor_reg[sel_reg]
        && !lor_reg[~sel_reg] |=> sel_reg != $past(sel_reg)
        && state_reg != DPS_HOLD;
    endproperty
    a_sw: assert property (p_sw) else $error("no hitless switch");
    property p_den;
        !denominator_select |=> den_reg[NUM_W-1:DEN24_W] == '0
        && den_reg[DEN24_W-1:0] == $past(den24_cfg);
    endproperty
    a_den: assert property (p_den) else $error("bad 24-bit denominator");
    property p_dco;
        dco_en && step_up_sw && !step_dn_sw && !step_dn_pin
        |=> dco_reg == $past(dco_reg) + $past(frequency_deviation_step_reg);
    endproperty
    a_dco: assert property (p_dco) else $error("offset step missed");
    property p_hexit;
        state_reg == DPS_HOLD && lor_reg != 2'b11 |=> state_reg == DPS_ACQ;
    endproperty
    a_hexit: assert property (p_hexit) else $error("holdover not left");
    property p_hstay;
        state_reg == DPS_HOLD && lor_reg == 2'b11 |=> state_reg == DPS_HOLD;
    endproperty
    a_hstay: assert property (p_hstay) else $error("holdover left early");
endmodule : dps_top

/* File: dps_top_tb_top.sv */
/*
 * Self-checking bench of the DPLL control block.
 * Assumes a 20 MHz clock and the edge model on the far side.
 */
module dps_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dps_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic                   mclk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   run = 1'b0;
    logic [NREF-1:0]        ref_edge;
    logic                   casc_edge;
    logic                   fb_edge;
    dps_mon_t               mon_level = '0;
    dps_mon_t               mon_thr = {(NREF * NMON){8'h0A}};
    dps_men_t               mon_en = '0;
    logic [NREF-1:0][PRIO_W-1:0] prio = {2'h0, 2'h1};
    logic                   man_sw = 1'b0;
    logic                   man_pin = 1'b0;
    logic                   man_sel_sw = 1'b0;
    logic                   man_sel_pin = 1'b0;
    logic                   src_casc = 1'b0;
    logic                   apll_ref_cfg = 1'b0;
    logic                   dco_en = 1'b1;
    logic [3:0]             stp = 4'h0;
    logic                   cfg_wr = 1'b0;
    logic [NUM_W-1:0]       cfg_frequency_deviation_step = 40'h00_0000_1234;
    logic                   denominator_select = 1'b1;
    logic [DEN24_W-1:0]     den24_cfg = 24'hABCDEF;
    logic [NREF-1:0]        lor_clr = 2'h0;
    logic [NUM_W-1:0]       num_reg;
    logic [NUM_W-1:0]       den_reg;
    logic                   sel_reg;
    dps_state_e             state_reg;
    logic [NREF-1:0]        lor_reg;
    logic [NREF-1:0]        lor_sticky_reg;
    logic                   locked_reg;
    logic                   apll_ref_reg;
    logic [NUM_W-1:0]       exp_num;
    int                     error_cnt = 0;
    int                     cmp_count = 0;
    int                     cyc_cnt = 0;
    logic [3:0]             seq [8] = '{4'h8, 4'h2, 4'h8, 4'h4, 4'h1,
                                        4'h9, 4'h6, 4'h8};

    always #25 mclk = ~mclk;

    // A lag of three cycles gives a phase error of two at each sample
    dps_ref_model #(.PER(8), .LAG(3)) i_dps_ref_model (.mclk(mclk),
        .rst_n(rst_n), .run(run), .ref_edge(ref_edge),
        .casc_edge(casc_edge), .fb_edge(fb_edge));

    dps_top i_dps_top (.mclk(mclk), .rst_n(rst_n), .ref_edge(ref_edge),
        .casc_edge(casc_edge), .fb_edge(fb_edge), .mon_level(mon_level),
        .mon_thr(mon_thr), .mon_en(mon_en), .prio(prio), .man_sw(man_sw),
        .man_pin(man_pin), .man_sel_sw(man_sel_sw),
        .man_sel_pin(man_sel_pin), .src_casc(src_casc),
        .apll_ref_cfg(apll_ref_cfg), .dco_en(dco_en),
        .step_up_sw(stp[3]), .step_dn_sw(stp[2]), .step_up_pin(stp[1]),
        .step_dn_pin(stp[0]), .cfg_wr(cfg_wr), .cfg_kp_sh(ROM_KP_SH),
        .cfg_ki_sh(ROM_KI_SH), .cfg_frequency_deviation_step(cfg_frequency_deviation_step),
        .denominator_select(denominator_select), .den24_cfg(den24_cfg),
        .lor_clr(lor_clr), .num_reg(num_reg), .den_reg(den_reg),
        .sel_reg(sel_reg), .state_reg(state_reg), .lor_reg(lor_reg),
        .lor_sticky_reg(lor_sticky_reg), .locked_reg(locked_reg),
        .apll_ref_reg(apll_ref_reg));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string nm, input logic [39:0] seen,
                         input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Outputs are read at the falling edge, clear of the update edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : tick

    task automatic mon(input int i, input int m, input logic en,
                       input logic [7:0] lvl);
        @(posedge mclk);
        mon_en[i][m]    <= en;
        mon_level[i][m] <= lvl;
    endtask : mon

    task automatic fail_ref(input int i, input logic f);
        mon(i, MON_FREQ, 1'b1, f ? 8'h0B : 8'h00);
        tick(4);
    endtask : fail_ref

    always @(posedge mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(15);
        check("num_rst", num_reg, NUM_NOM);
        check("den_rst", den_reg, DEN_FIXED);
        check("state_rst", state_reg, DPS_FREE);
        check("flags_rst", {sel_reg, locked_reg, lor_reg}, 4'h0);
        @(posedge mclk);
        rst_n <= 1'b1;
        tick(4);
        check("sel_prio", sel_reg, 1'b1);
        @(posedge mclk);
        denominator_select <= 1'b0;
        apll_ref_cfg       <= 1'b1;
        tick(2);
        check("den24", den_reg, {16'h0000, den24_cfg});
        check("apll_casc", apll_ref_reg, 1'b1);
        @(posedge mclk);
        denominator_select <= 1'b1;
        apll_ref_cfg       <= 1'b0;
        tick(2);
        check("den40", den_reg, DEN_FIXED);
        check("apll_xo", apll_ref_reg, 1'b0);
        // A step before any write must use the built-in step size
        @(posedge mclk);
        stp <= 4'h8;
        @(posedge mclk);
        stp <= 4'h0;
        tick(1);
        exp_num = NUM_NOM + ROM_FREQUENCY_DEVIATION_STEP;
        check("frequency_deviation_step_rom", num_reg, exp_num);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        // Feedback edges are off, so only steps move the numerator
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            dco_en <= (k < 7);
            stp    <= seq[k];
            @(posedge mclk);
            stp <= 4'h0;
            if (k < 7 && (seq[k][3] | seq[k][1]) && !(seq[k][2] | seq[k][0]))
                exp_num = exp_num + cfg_frequency_deviation_step;
            if (k < 7 && (seq[k][2] | seq[k][0]) && !(seq[k][3] | seq[k][1]))
                exp_num = exp_num - cfg_frequency_deviation_step;
            tick(1);
            check("dco_num", num_reg, exp_num);
        end
        fail_ref(1, 1'b1);
        check("hitless_sel", sel_reg, 1'b0);
        check("hitless_st", state_reg, DPS_ACQ);
        fail_ref(0, 1'b1);
        check("hold_st", state_reg, DPS_HOLD);
        fail_ref(0, 1'b0);
        check("leave_hold", {state_reg, sel_reg}, {DPS_ACQ, 1'b0});
        fail_ref(1, 1'b0);
        check("reselect", sel_reg, 1'b1);
        @(posedge mclk);
        man_sw <= 1'b1;
        tick(4);
        check("man_sw", sel_reg, 1'b0);
        @(posedge mclk);
        man_pin     <= 1'b1;
        man_sel_pin <= 1'b1;
        tick(4);
        check("man_pin", sel_reg, 1'b1);
        fail_ref(1, 1'b1);
        check("man_hold", state_reg, DPS_HOLD);
        @(posedge mclk);
        man_sw  <= 1'b0;
        man_pin <= 1'b0;
        fail_ref(1, 1'b0);
        // Crystal kept for the analog side while the loop tracks cascade
        @(posedge mclk);
        src_casc <= 1'b1;
        fail_ref(0, 1'b1);
        fail_ref(1, 1'b1);
        check("casc_lor", lor_reg, 2'h3);
        check("casc_nohold", state_reg, DPS_ACQ);
        fail_ref(0, 1'b0);
        fail_ref(1, 1'b0);
        @(posedge mclk);
        src_casc <= 1'b0;
        mon_en   <= '0;
        for (int i = 0; i < NREF; i++) begin
            for (int m = 0; m < NMON; m++) begin
                mon(i, m, 1'b0, 8'h0B);
                tick(3);
                check("mon_off", lor_reg, 2'h0);
                mon(i, m, 1'b1, 8'h0B);
                tick(3);
                check("mon_fail", lor_reg, 2'h1 << i);
                mon(i, m, 1'b1, 8'h0A);
                tick(3);
                check("mon_thr", lor_reg, 2'h0);
                mon(i, m, 1'b0, 8'h00);
            end
        end
        check("sticky", lor_sticky_reg, 2'h3);
        @(posedge mclk);
        lor_clr <= 2'h3;
        @(posedge mclk);
        lor_clr <= 2'h0;
        tick(2);
        check("sticky_clr", lor_sticky_reg, 2'h0);
        @(posedge mclk);
        rst_n <= 1'b0;
        tick(2);
        check("num_rst2", num_reg, NUM_NOM);
        @(posedge mclk);
        rst_n <= 1'b1;
        run   <= 1'b1;
        for (int k = 0; k < 800 && locked_reg !== 1'b1; k++)
            @(posedge mclk);
        tick(120);
        // First error of two is taken whole; its shifted terms are zero
        exp_num = NUM_NOM + 40'h00_0000_0002;
        check("locked", {locked_reg, state_reg}, {1'b1, DPS_LOCK});
        check("lock_num", num_reg, exp_num);
        fail_ref(1, 1'b1);
        check("lock_switch", {locked_reg, sel_reg}, 2'h2);
        fail_ref(0, 1'b1);
        check("hold_enter", state_reg, DPS_HOLD);
        check("hold_word", num_reg, exp_num);
        stop_test();
    end
endmodule : dps_top_tb_top
